// ===== rtl/dcs_top.sv
// Register staging and application of the 10-bit current DAC code.
`timescale 1ns/1ps
module dcs_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic dac_enable,
  input wire logic mux_source_select,
  output logic [9:0] dac_code,
  output logic dac_power_down,
  output logic small_source_enable,
  output logic mux_from_dac,
  output logic [9:0] dac_p_level,
  output logic [10:0] dac_n_level,
  output logic [4:0] mux_current_code
);

  logic [7:0] high_reg, high_next;
  logic [1:0] low_reg, low_next;
  logic [9:0] code_reg, code_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wr_high, wr_low;

  dcs_ctrl_if ctrl_bus ();

  // -------------------------------------------------------------------------
  // Address decoding
  // -------------------------------------------------------------------------
  // One match function serves the write strobes and the read multiplexer.
  function automatic logic addr_hit(input logic [4:0] addr,
    input logic [4:0] target);
    return addr == target;
  endfunction

  // -------------------------------------------------------------------------
  // Register writes and code application
  // -------------------------------------------------------------------------
  assign wr_high = reg_wr && addr_hit(reg_addr, dcs_pkg::ADDR_CODE_HIGH);
  assign wr_low = reg_wr && addr_hit(reg_addr, dcs_pkg::ADDR_CODE_LOW);

  always_comb begin
    high_next = high_reg;
    low_next = low_reg;
    code_next = code_reg;
    if (wr_low) begin
      low_next = reg_wdata[1:0];
    end
    if (wr_high) begin
      high_next = reg_wdata;
      code_next = {reg_wdata, low_reg};
    end
  end

  // -------------------------------------------------------------------------
  // Register reads
  // -------------------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (addr_hit(reg_addr, dcs_pkg::ADDR_CODE_HIGH)) begin
        rdata_next = high_reg;
      end else if (addr_hit(reg_addr, dcs_pkg::ADDR_CODE_LOW)) begin
        rdata_next = {6'h00, low_reg};
      end else begin
        rdata_next = dcs_pkg::READ_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      high_reg <= dcs_pkg::HIGH_RESET;
      low_reg <= dcs_pkg::LOW_RESET;
      code_reg <= dcs_pkg::CODE_RESET;
      rdata_reg <= dcs_pkg::READ_ZERO;
    end else begin
      high_reg <= high_next;
      low_reg <= low_next;
      code_reg <= code_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign dac_code = code_reg;

  // -------------------------------------------------------------------------
  // Output stage
  // -------------------------------------------------------------------------
  assign ctrl_bus.code = code_reg;
  assign ctrl_bus.enable = dac_enable;
  assign ctrl_bus.use_dac_for_mux = mux_source_select;

  dcs_output_stage u_output_stage (
    .core_clk(core_clk),
    .srst(srst),
    .ctrl(ctrl_bus.sink),
    .dac_power_down(dac_power_down),
    .small_source_enable(small_source_enable),
    .mux_from_dac(mux_from_dac),
    .dac_p_level(dac_p_level),
    .dac_n_level(dac_n_level),
    .mux_current_code(mux_current_code)
  );

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  property p_high_applies;
    @(posedge core_clk) disable iff (srst)
    wr_high |=> dac_code == {$past(reg_wdata), $past(low_reg)};
  endproperty
  a_high_applies: assert property (p_high_applies)
    else $error("High write did not apply the combined code.");

  property p_low_stores;
    @(posedge core_clk) disable iff (srst)
    wr_low && !wr_high |=> low_reg == $past(reg_wdata[1:0])
      && $stable(dac_code);
  endproperty
  a_low_stores: assert property (p_low_stores)
    else $error("Low write stored wrong bits or moved the code.");

  property p_low_reads_zero;
    @(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == dcs_pkg::ADDR_CODE_LOW |=>
      reg_rdata[7:2] == 6'h00 && reg_rdata[1:0] == $past(low_reg);
  endproperty
  a_low_reads_zero: assert property (p_low_reads_zero)
    else $error("Low register read back wrong value.");

  property p_high_reads;
    @(posedge core_clk) disable iff (srst)
    reg_rd && reg_addr == dcs_pkg::ADDR_CODE_HIGH |=>
      reg_rdata == $past(high_reg) && $past(dac_code[9:2]) == reg_rdata;
  endproperty
  a_high_reads: assert property (p_high_reads)
    else $error("High register read does not match the code.");

  property p_reset_clears;
    @(posedge core_clk)
    srst |=> high_reg == 8'h00 && low_reg == 2'h0 && dac_code == 10'h000;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("Code registers not cleared by reset.");

  property p_low_persists;
    @(posedge core_clk) disable iff (srst)
    !wr_low ##1 wr_high |=> dac_code[1:0] == $past(low_reg, 2);
  endproperty
  a_low_persists: assert property (p_low_persists)
    else $error("Staged low bits changed without a low write.");

  property p_code_holds;
    @(posedge core_clk) disable iff (srst)
    !wr_high |=> $stable(dac_code);
  endproperty
  a_code_holds: assert property (p_code_holds)
    else $error("Applied code moved without a high write.");

  property p_high_holds;
    @(posedge core_clk) disable iff (srst)
    !wr_high |=> $stable(high_reg);
  endproperty
  a_high_holds: assert property (p_high_holds)
    else $error("High register moved without a high write.");

  property p_low_holds;
    @(posedge core_clk) disable iff (srst)
    !wr_low |=> $stable(low_reg);
  endproperty
  a_low_holds: assert property (p_low_holds)
    else $error("Staged low bits moved without a low write.");

  property p_levels_follow_code;
    @(posedge core_clk) disable iff (srst)
    dac_enable && !mux_source_select |=>
      dac_p_level == $past(dac_code)
      && dac_n_level == dcs_pkg::FULL_SCALE - {1'b0, $past(dac_code)};
  endproperty
  a_levels_follow_code: assert property (p_levels_follow_code)
    else $error("Output levels do not follow the applied code.");

  property p_power_down_pins;
    @(posedge core_clk) disable iff (srst)
    !dac_enable |=> dac_power_down && !mux_from_dac
      && dac_n_level == 11'h000;
  endproperty
  a_power_down_pins: assert property (p_power_down_pins)
    else $error("Converter outputs active while powered down.");

  property p_pins_idle_in_mux;
    @(posedge core_clk) disable iff (srst)
    mux_source_select |=> !small_source_enable
      && dac_p_level == 10'h000 && dac_n_level == 11'h000;
  endproperty
  a_pins_idle_in_mux: assert property (p_pins_idle_in_mux)
    else $error("Output pins driven while the converter feeds the mux.");

  property p_general_purpose;
    @(posedge core_clk) disable iff (srst)
    dac_enable && !mux_source_select |=> small_source_enable
      && !mux_from_dac && !dac_power_down && mux_current_code == 5'h00;
  endproperty
  a_general_purpose: assert property (p_general_purpose)
    else $error("Converter not freed for the output pins.");
endmodule

// ===== rtl/dcs_pkg.sv
// Constants shared by the current DAC code staging block.
package dcs_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int CODE_W = 10;
  localparam int LOW_W = 2;
  localparam int MUX_W = 5;
  localparam logic [4:0] ADDR_CODE_HIGH = 5'h0e;
  localparam logic [4:0] ADDR_CODE_LOW = 5'h0f;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  localparam logic [1:0] LOW_RESET = 2'h0;
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [10:0] FULL_SCALE = 11'h400;
  localparam logic [4:0] MUX_CODE_MAX = 5'h1f;
endpackage

// ===== rtl/dcs_ctrl_if.sv
// Interface carrying the applied code and mode controls to the output stage.
`timescale 1ns/1ps
interface dcs_ctrl_if;
  logic [9:0] code;
  logic enable;
  logic use_dac_for_mux;
  modport src (output code, output enable, output use_dac_for_mux);
  modport sink (input code, input enable, input use_dac_for_mux);
endinterface

// ===== rtl/dcs_output_stage.sv
// Output stage: power down, source routing and output level computation.
`timescale 1ns/1ps
module dcs_output_stage (
  input wire logic core_clk,
  input wire logic srst,
  dcs_ctrl_if.sink ctrl,
  output logic dac_power_down,
  output logic small_source_enable,
  output logic mux_from_dac,
  output logic [9:0] dac_p_level,
  output logic [10:0] dac_n_level,
  output logic [4:0] mux_current_code
);

  logic power_down_reg, power_down_next;
  logic small_src_reg, small_src_next;
  logic mux_dac_reg, mux_dac_next;
  logic [9:0] p_reg, p_next;
  logic [10:0] n_reg, n_next;
  logic [4:0] mux_reg, mux_next;

  // -------------------------------------------------------------------------
  // Next-state computation
  // -------------------------------------------------------------------------
  always_comb begin
    power_down_next = !ctrl.enable;
    small_src_next = !ctrl.use_dac_for_mux;
    mux_dac_next = ctrl.use_dac_for_mux && ctrl.enable;
    p_next = 10'h000;
    n_next = 11'h000;
    mux_next = 5'h00;
    if (ctrl.enable && !ctrl.use_dac_for_mux) begin
      // True output tracks the code, complement tracks full scale minus code.
      p_next = ctrl.code;
      n_next = dcs_pkg::FULL_SCALE - {1'b0, ctrl.code};
    end else if (ctrl.enable) begin
      // Codes above the usable range saturate at MUX_CODE_MAX.
      if (ctrl.code > {5'h00, dcs_pkg::MUX_CODE_MAX}) begin
        mux_next = dcs_pkg::MUX_CODE_MAX;
      end else begin
        mux_next = ctrl.code[4:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // State registers
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_down_reg <= 1'b1;
      small_src_reg <= 1'b1;
      mux_dac_reg <= 1'b0;
      p_reg <= 10'h000;
      n_reg <= 11'h000;
      mux_reg <= 5'h00;
    end else begin
      power_down_reg <= power_down_next;
      small_src_reg <= small_src_next;
      mux_dac_reg <= mux_dac_next;
      p_reg <= p_next;
      n_reg <= n_next;
      mux_reg <= mux_next;
    end
  end

  assign dac_power_down = power_down_reg;
  assign small_source_enable = small_src_reg;
  assign mux_from_dac = mux_dac_reg;
  assign dac_p_level = p_reg;
  assign dac_n_level = n_reg;
  assign mux_current_code = mux_reg;

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  property p_power_down;
    @(posedge core_clk) disable iff (srst)
    !ctrl.enable |=> dac_power_down && dac_p_level == 10'h000
      && mux_current_code == 5'h00;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("Converter not powered down while disabled.");

  property p_small_source;
    @(posedge core_clk) disable iff (srst)
    !ctrl.use_dac_for_mux |=> small_source_enable && !mux_from_dac;
  endproperty
  a_small_source: assert property (p_small_source)
    else $error("Small source not selected for the multiplexer.");

  property p_dac_source;
    @(posedge core_clk) disable iff (srst)
    ctrl.use_dac_for_mux && ctrl.enable |=> !small_source_enable
      && mux_from_dac && dac_p_level == 10'h000;
  endproperty
  a_dac_source: assert property (p_dac_source)
    else $error("Converter not routed to the multiplexer.");

  property p_complement;
    @(posedge core_clk) disable iff (srst)
    ctrl.enable && !ctrl.use_dac_for_mux |=>
      dac_p_level == $past(ctrl.code)
      && ({1'b0, dac_p_level} + dac_n_level) == dcs_pkg::FULL_SCALE;
  endproperty
  a_complement: assert property (p_complement)
    else $error("Complementary levels do not sum to full scale.");

  property p_mux_scale;
    @(posedge core_clk) disable iff (srst)
    ctrl.enable && ctrl.use_dac_for_mux && ctrl.code < 10'h020 |=>
      mux_current_code == $past(ctrl.code[4:0]);
  endproperty
  a_mux_scale: assert property (p_mux_scale)
    else $error("Multiplexer current does not follow the code.");
endmodule

// ===== testbench/dcs_host_model.sv
// Host model that writes and reads the code staging registers.
`timescale 1ns/1ps
module dcs_host_model (
  input wire logic core_clk,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse so stale values never look valid.
  task automatic write(input logic [4:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  task automatic read(input logic [4:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  task automatic set_code(input logic [9:0] c);
    write(dcs_pkg::ADDR_CODE_LOW, {6'h00, c[1:0]});
    write(dcs_pkg::ADDR_CODE_HIGH, c[9:2]);
  endtask
endmodule

// ===== testbench/dcs_top_tb.sv
// Self-checking bench for the current DAC code staging block.
`timescale 1ns/1ps
module dcs_top_tb;
  logic core_clk = 1'b0;
  logic srst, reg_wr, reg_rd, dac_enable, mux_source_select;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [9:0] dac_code, dac_p_level;
  logic [10:0] dac_n_level;
  logic [4:0] mux_current_code;
  logic dac_power_down, small_source_enable, mux_from_dac;
  logic [9:0] gp_codes [6] = '{10'h000, 10'h001, 10'h3fe, 10'h3ff,
                               10'h100, 10'h300};
  logic [9:0] mux_codes [4] = '{10'h000, 10'h008, 10'h018, 10'h01f};
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2.5 core_clk = ~core_clk;
  dcs_host_model dcs_host_model_inst (.core_clk(core_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  dcs_top dcs_top_inst (.core_clk(core_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac_enable(dac_enable),
    .mux_source_select(mux_source_select), .dac_code(dac_code),
    .dac_power_down(dac_power_down),
    .small_source_enable(small_source_enable),
    .mux_from_dac(mux_from_dac), .dac_p_level(dac_p_level),
    .dac_n_level(dac_n_level), .mux_current_code(mux_current_code));
  task automatic check(input string what, input logic [10:0] seen,
                       input logic [10:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_check(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] v;
    dcs_host_model_inst.read(a, v);
    check("reg_rdata", {3'h0, v}, {3'h0, exp});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    dac_enable = 1'b0;
    mux_source_select = 1'b0;
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    check("dac_code", dac_code, 11'h000);
    check("power_down", dac_power_down, 11'h001);
    check("small_src", small_source_enable, 11'h001);
    rd_check(dcs_pkg::ADDR_CODE_HIGH, 8'h00);
    rd_check(dcs_pkg::ADDR_CODE_LOW, 8'h00);
    dcs_host_model_inst.write(dcs_pkg::ADDR_CODE_LOW, 8'hff);
    rd_check(dcs_pkg::ADDR_CODE_LOW, 8'h03);
    dcs_host_model_inst.write(dcs_pkg::ADDR_CODE_HIGH, 8'ha5);
    check("dac_code", dac_code, 11'h297);
    rd_check(dcs_pkg::ADDR_CODE_HIGH, 8'ha5);
    dcs_host_model_inst.write(dcs_pkg::ADDR_CODE_HIGH, 8'h12);
    check("dac_code", dac_code, 11'h04b);
    rd_check(5'h10, 8'h00);
    check("p_off", dac_p_level, 11'h000);
    dac_enable = 1'b1;
    @(negedge core_clk);
    check("power_down", dac_power_down, 11'h000);
    check("mux_from_dac", mux_from_dac, 11'h000);
    for (int i = 0; i < 6; i++) begin
      dcs_host_model_inst.set_code(gp_codes[i]);
      check("dac_code", dac_code, gp_codes[i]);
      @(negedge core_clk);
      check("p_level", dac_p_level, gp_codes[i]);
      check("n_level", dac_n_level, 11'h400 - gp_codes[i]);
    end
    mux_source_select = 1'b1;
    @(negedge core_clk);
    check("mux_from_dac", mux_from_dac, 11'h001);
    check("small_src", small_source_enable, 11'h000);
    for (int i = 0; i < 4; i++) begin
      dcs_host_model_inst.set_code(mux_codes[i]);
      @(negedge core_clk);
      check("mux_code", mux_current_code, mux_codes[i]);
      check("p_level", dac_p_level, 11'h000);
    end
    dac_enable = 1'b0;
    @(negedge core_clk);
    check("power_down", dac_power_down, 11'h001);
    check("mux_code", mux_current_code, 11'h000);
    srst = 1'b1;
    @(negedge core_clk);
    srst = 1'b0;
    check("dac_code", dac_code, 11'h000);
    rd_check(dcs_pkg::ADDR_CODE_HIGH, 8'h00);
    rd_check(dcs_pkg::ADDR_CODE_LOW, 8'h00);
    dcs_host_model_inst.write(dcs_pkg::ADDR_CODE_HIGH, 8'h01);
    check("dac_code", dac_code, 11'h004);
    end_of_test();
  end
endmodule
